//--- include/cko_cfg.svh
// cko_cfg.svh: register map constants of the clock output control bank
`ifndef CKO_CFG_SVH
`define CKO_CFG_SVH
`define CKO_SLAVE_ADDR 7'h69
`define CKO_NUM_REGS 7'h07
`define CKO_BLOCK_COUNT 8'h07
`define CKO_OFF_FREQ_SRC 3'h0
`define CKO_OFF_SPREAD_CFG 3'h1
`define CKO_OFF_SE_EN 3'h2
`define CKO_OFF_UPPER_EN 3'h3
`define CKO_OFF_LOWER_EN 3'h4
`define CKO_OFF_CREQ_AD 3'h5
`define CKO_OFF_CREQ_EH 3'h6
`define CKO_RST_FREQ_SRC 8'h01
`define CKO_RST_SPREAD_CFG 8'h03
`define CKO_RST_SE_EN 8'hff
`define CKO_RST_UPPER_EN 8'hff
`define CKO_RST_LOWER_EN 8'hff
`define CKO_RST_CREQ_AD 8'h00
`define CKO_RST_CREQ_EH 8'h00
`define CKO_WM_FREQ_SRC 8'h17
`define CKO_WM_SPREAD_CFG 8'h7e
`define CKO_WM_UPPER_EN 8'hfd
`define CKO_WM_CREQ_EH 8'hf3
`define CKO_WM_FULL 8'hff
`define CKO_PIN_RST 18'h301ff
`define CKO_B_MGMT 4
`define CKO_B_MAIN_SEL 2
`define CKO_B_STORAGE_SEL 1
`define CKO_B_KEEP 0
`define CKO_B_A_MODE 6
`define CKO_B_C_MODE 5
`define CKO_B_A_SPREAD 1
`define CKO_B_C_SPREAD 0
`define CKO_B_PANEL_STP 1
`define CKO_B_PCIE_STP 0
`endif

//--- include/cko_field_if.sv
// cko_field_if.sv: register fields to the output gating and enables back
`timescale 1ns/1ps
interface cko_field_if;
  import cko_pkg::*;
  cko_bank_t regs;
  logic gfx_strap;
  cko_en_t en;
  modport bank(output regs, output gfx_strap, input en);
  modport gate(input regs, input gfx_strap, output en);
endinterface

//--- include/cko_pkg.sv
// cko_pkg.sv: types shared by the clock output control bank
package cko_pkg;
  typedef logic [6:0][7:0] cko_bank_t;
  typedef enum logic [4:0] {
    CKO_IDLE = 5'h01,
    CKO_RX = 5'h02,
    CKO_RACK = 5'h04,
    CKO_TX = 5'h08,
    CKO_TACK = 5'h10
  } cko_bus_st_t;
  typedef enum logic [1:0] {
    CKO_PH_ADDR = 2'h0,
    CKO_PH_CMD = 2'h1,
    CKO_PH_COUNT = 2'h2,
    CKO_PH_DATA = 2'h3
  } cko_phase_t;
  typedef struct packed {
    logic ref_en;
    logic usb_en;
    logic free_pci_out0_en;
    logic [4:0] pci_en;
    logic [11:0] src_en;
    logic [1:0] cpu_en;
    logic dot_clock_96_en;
    logic panel_clock_100_en;
  } cko_en_t;
endpackage

//--- src/cko_ctrl_top.sv
// cko_ctrl_top.sv: clock output control register bank behind its bus slave
`timescale 1ns/1ps
// Function
// - byte0 7:5 read latched frequency straps
// - mode bit set by write or stop combination
// - source select bit picks main pcie pll
// - storage clock source bit, main or second
// - keep bit saves config across power down
// - shared output route forced by graphics strap
// - spread mode bits, down or center
// - pll config code applies only when source select bit clear
// - single-ended output enables, reset on
// - upper pcie output enables, reset on
// - lower pcie and cpu enables, reset on
// - spread modulation enables, reset on
// - request a enable and route 0/2
// - request b enable and route 1/4
// - request c enable and route 0/2
// - request d enable and route 1/4
// - requests e to h tied fixed
// - panel clock stoppable by pci stop
// - pcie clocks stoppable by pci stop
// - answer only bus address d2
// - command bit7 byte access, else block
// - registers load defaults at power up
`include "cko_cfg.svh"
module cko_ctrl_top
  import cko_pkg::*;
(
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic smb_clk_in,
  input wire logic smb_data_in,
  output logic smb_data_out,
  output logic smb_data_oe_out,
  input wire logic [2:0] cpu_freq_strap_in,
  input wire logic graphics_clock_strap_in,
  input wire logic power_good_in,
  input wire logic power_down_in,
  input wire logic cpu_stop_in,
  input wire logic pci_stop_n_in,
  input wire logic [7:0] clkreq_n_in,
  output cko_en_t clk_en_out,
  output logic mgmt_engine_mode_out,
  output logic pcie_main_source_sel_out,
  output logic storage_clock_source_sel_out,
  output logic shared_out0_route_out,
  output logic pll_a_spread_mode_out,
  output logic pll_c_spread_mode_out,
  output logic pll_a_spread_on_out,
  output logic pll_c_spread_on_out,
  output logic [3:0] pll_c_cfg_out,
  output logic pll_c_cfg_apply_out
);
  typedef struct packed {
    cko_bus_st_t st;
    cko_phase_t ph;
    logic [3:0] bits;
    logic [7:0] sh;
    logic rd;
    logic blk;
    logic cnt_sent;
    logic nack;
    logic [6:0] idx;
    logic oe;
    logic lvl;
    logic scl_d;
    logic sda_d;
    cko_bank_t regs;
    logic [2:0] fs;
    logic gfx;
    logic strap_done;
    logic pd_d;
    logic route;
    logic apply;
    cko_en_t en;
  } cko_top_st_t;

  localparam cko_bank_t DEF = {`CKO_RST_CREQ_EH, `CKO_RST_CREQ_AD, `CKO_RST_LOWER_EN,
    `CKO_RST_UPPER_EN, `CKO_RST_SE_EN, `CKO_RST_SPREAD_CFG, `CKO_RST_FREQ_SRC};

  cko_top_st_t r_reg, r_next;
  logic [17:0] pin_q;
  logic scl, sda, pgood, pd, cstop, pstop_n, gfx_pin;
  logic [2:0] fs_pin;
  logic [7:0] creq_n;
  logic rise, fall, start, stop, load;
  logic [7:0] tx;

  cko_field_if fld();

  cko_sync #(
    .W(18),
    .RST(`CKO_PIN_RST)
  ) u_sync (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .d_in({smb_clk_in, smb_data_in, cpu_freq_strap_in, graphics_clock_strap_in, power_good_in,
      power_down_in, cpu_stop_in, pci_stop_n_in, clkreq_n_in}),
    .q_out(pin_q)
  );

  cko_out_gate u_gate (
    .fld(fld.gate),
    .clkreq_n_in(creq_n),
    .pci_stop_n_in(pstop_n)
  );

  assign scl = pin_q[17];
  assign sda = pin_q[16];
  assign fs_pin = pin_q[15:13];
  assign gfx_pin = pin_q[12];
  assign pgood = pin_q[11];
  assign pd = pin_q[10];
  assign cstop = pin_q[9];
  assign pstop_n = pin_q[8];
  assign creq_n = pin_q[7:0];
  assign fld.regs = r_reg.regs;
  assign fld.gfx_strap = r_reg.gfx;

  function automatic logic [7:0] rd_byte(input cko_bank_t b, input logic [6:0] i,
                                         input logic [2:0] f, input logic g);
    logic [7:0] v;
    v = 8'h00;
    if (i == 7'h00) begin
      v = {f, b[0][4:0]};
    end else if (i == 7'h01) begin
      v = {!g, b[1][6:0]};
    end else if (i < `CKO_NUM_REGS) begin
      v = b[i[2:0]];
    end
    return v;
  endfunction

  function automatic logic [7:0] wr_mask(input logic [2:0] i);
    logic [7:0] m;
    m = `CKO_WM_FULL;
    if (i == `CKO_OFF_FREQ_SRC) m = `CKO_WM_FREQ_SRC;
    if (i == `CKO_OFF_SPREAD_CFG) m = `CKO_WM_SPREAD_CFG;
    if (i == `CKO_OFF_UPPER_EN) m = `CKO_WM_UPPER_EN;
    if (i == `CKO_OFF_CREQ_EH) m = `CKO_WM_CREQ_EH;
    return m;
  endfunction

  assign rise = scl && !r_reg.scl_d;
  assign fall = !scl && r_reg.scl_d;
  assign start = scl && r_reg.scl_d && r_reg.sda_d && !sda;
  assign stop = scl && r_reg.scl_d && !r_reg.sda_d && sda;

  always_comb begin
    r_next = r_reg;
    load = 1'b0;
    tx = 8'h00;
    r_next.scl_d = scl;
    r_next.sda_d = sda;
    r_next.pd_d = pd;
    r_next.en = fld.en;
    r_next.route = !r_reg.gfx;
    r_next.apply = !r_reg.regs[0][`CKO_B_MAIN_SEL];
    // one-shot strap capture at the first power good
    if (pgood && !r_reg.strap_done) begin
      r_next.fs = fs_pin;
      r_next.gfx = gfx_pin;
      r_next.strap_done = 1'b1;
    end
    if (start) begin
      r_next.st = CKO_RX;
      r_next.ph = CKO_PH_ADDR;
      r_next.bits = 4'h0;
      r_next.oe = 1'b0;
    end else if (stop) begin
      r_next.st = CKO_IDLE;
      r_next.oe = 1'b0;
    end else begin
      unique case (r_reg.st)
        CKO_IDLE: begin
        end
        CKO_RX: begin
          if (rise) begin
            r_next.sh = {r_reg.sh[6:0], sda};
            r_next.bits = r_reg.bits + 4'h1;
          end else if (fall && r_reg.bits == 4'h8) begin
            r_next.st = CKO_RACK;
            r_next.oe = 1'b1;
            unique case (r_reg.ph)
              CKO_PH_ADDR: begin
                if (r_reg.sh[7:1] != `CKO_SLAVE_ADDR) begin
                  r_next.st = CKO_IDLE;
                  r_next.oe = 1'b0;
                end else begin
                  r_next.rd = r_reg.sh[0];
                  r_next.cnt_sent = 1'b0;
                  r_next.ph = CKO_PH_CMD;
                end
              end
              CKO_PH_CMD: begin
                r_next.blk = !r_reg.sh[7];
                r_next.idx = r_reg.sh[7] ? r_reg.sh[6:0] : 7'h00;
                r_next.ph = r_reg.sh[7] ? CKO_PH_DATA : CKO_PH_COUNT;
              end
              CKO_PH_COUNT: begin
                r_next.ph = CKO_PH_DATA;
              end
              CKO_PH_DATA: begin
                if (r_reg.idx < `CKO_NUM_REGS) begin
                  // reserved and strap bits keep their value
                  r_next.regs[r_reg.idx[2:0]] = (r_reg.regs[r_reg.idx[2:0]] & ~wr_mask(r_reg.idx[2:0]))
                    | (r_reg.sh & wr_mask(r_reg.idx[2:0]));
                end
                r_next.idx = r_reg.idx + 7'h01;
              end
            endcase
          end
        end
        CKO_RACK: begin
          if (fall) begin
            r_next.oe = 1'b0;
            r_next.bits = 4'h0;
            if (r_reg.rd) begin
              load = 1'b1;
            end else begin
              r_next.st = CKO_RX;
            end
          end
        end
        CKO_TX: begin
          if (fall) begin
            if (r_reg.bits == 4'h8) begin
              r_next.oe = 1'b0;
              r_next.st = CKO_TACK;
            end else begin
              r_next.sh = {r_reg.sh[6:0], 1'b0};
              r_next.oe = !r_reg.sh[6];
              r_next.bits = r_reg.bits + 4'h1;
            end
          end
        end
        CKO_TACK: begin
          if (rise) begin
            r_next.nack = sda;
          end else if (fall) begin
            if (r_reg.nack) begin
              r_next.st = CKO_IDLE;
            end else begin
              load = 1'b1;
            end
          end
        end
      endcase
    end
    // next byte out: block reads lead with the byte count
    if (load) begin
      if (r_reg.blk && !r_reg.cnt_sent) begin
        tx = `CKO_BLOCK_COUNT;
      end else begin
        tx = rd_byte(r_reg.regs, r_reg.idx, r_reg.fs, r_reg.gfx);
        r_next.idx = r_reg.idx + 7'h01;
      end
      r_next.cnt_sent = 1'b1;
      r_next.sh = tx;
      r_next.oe = !tx[7];
      r_next.bits = 4'h1;
      r_next.st = CKO_TX;
    end
    if (pd && !r_reg.pd_d && !r_reg.regs[0][`CKO_B_KEEP]) begin
      r_next.regs = DEF;
    end
    if (pd && cstop && !pstop_n) begin
      r_next.regs[0][`CKO_B_MGMT] = 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      r_reg <= '0;
      r_reg.st <= CKO_IDLE;
      r_reg.ph <= CKO_PH_ADDR;
      r_reg.regs <= DEF;
      r_reg.scl_d <= 1'b1;
      r_reg.sda_d <= 1'b1;
      r_reg.route <= 1'b1;
      r_reg.apply <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign smb_data_out = r_reg.lvl;
  assign smb_data_oe_out = r_reg.oe;
  assign clk_en_out = r_reg.en;
  assign mgmt_engine_mode_out = r_reg.regs[0][`CKO_B_MGMT];
  assign pcie_main_source_sel_out = r_reg.regs[0][`CKO_B_MAIN_SEL];
  assign storage_clock_source_sel_out = r_reg.regs[0][`CKO_B_STORAGE_SEL];
  assign shared_out0_route_out = r_reg.route;
  assign pll_a_spread_mode_out = r_reg.regs[1][`CKO_B_A_MODE];
  assign pll_c_spread_mode_out = r_reg.regs[1][`CKO_B_C_MODE];
  assign pll_a_spread_on_out = r_reg.regs[4][`CKO_B_A_SPREAD];
  assign pll_c_spread_on_out = r_reg.regs[4][`CKO_B_C_SPREAD];
  assign pll_c_cfg_out = r_reg.regs[1][4:1];
  assign pll_c_cfg_apply_out = r_reg.apply;

  default clocking @(posedge mclk_in); endclocking
  default disable iff (srst_in);

  chk_strap_hold: assert property (r_reg.strap_done |=> $stable(r_reg.fs))
    else $error("latched straps changed");
  chk_mode_combo: assert property ((pd && cstop && !pstop_n) |=> mgmt_engine_mode_out)
    else $error("mode bit not set by stop combination");
  chk_cfg_apply: assert property (1'b1 |=> (pll_c_cfg_apply_out == !$past(pcie_main_source_sel_out)))
    else $error("config apply does not follow source select");
  chk_pd_clear: assert property ((pd && !r_reg.pd_d && !r_reg.regs[0][0] && !(cstop && !pstop_n))
    |=> (r_reg.regs == DEF))
    else $error("power down did not clear configuration");
  chk_route_strap: assert property (r_reg.strap_done |-> ##2 (shared_out0_route_out != r_reg.gfx))
    else $error("shared route not forced by strap");
  chk_src_stop: assert property ((r_reg.regs[6][0] && !pstop_n) |=> (clk_en_out.src_en == 12'h000))
    else $error("pcie outputs not stopped");
  chk_panel_stop: assert property ((r_reg.regs[6][1] && !pstop_n) |=> !clk_en_out.panel_clock_100_en)
    else $error("panel clock not stopped");
  chk_reserved_bits: assert property (1'b1 |-> (!r_reg.regs[0][3] && r_reg.regs[1][0] && r_reg.regs[3][1]
    && r_reg.regs[6][3:2] == 2'b00))
    else $error("reserved bit changed");
  chk_reset_vals: assert property ($past(srst_in) |-> (r_reg.regs == DEF))
    else $error("defaults not loaded at reset");
  chk_addr_nack: assert property ((r_reg.st == CKO_RX && r_reg.ph == CKO_PH_ADDR && fall && r_reg.bits == 4'h8
    && r_reg.sh[7:1] != `CKO_SLAVE_ADDR && !start && !stop) |=> (!smb_data_oe_out && r_reg.st == CKO_IDLE))
    else $error("foreign address acknowledged");
  chk_req_a_stop: assert property ((r_reg.regs[5][7:6] == 2'b10 && creq_n[0]) |=> !clk_en_out.src_en[0])
    else $error("request a did not stop its output");
  chk_req_e_stop: assert property ((r_reg.regs[6][7] && creq_n[4]) |=> !clk_en_out.src_en[6])
    else $error("request e did not stop its output");
  chk_gfx_force: assert property ((r_reg.strap_done && !r_reg.gfx) |=> (clk_en_out.src_en[1:0] == 2'b00))
    else $error("shared outputs not forced off by strap");
  chk_idle_quiet: assert property ((r_reg.st == CKO_IDLE) |-> !smb_data_oe_out)
    else $error("data line driven while idle");
  chk_count_first: assert property ((load && r_reg.blk && !r_reg.cnt_sent)
    |=> (r_reg.sh == `CKO_BLOCK_COUNT))
    else $error("block read did not lead with count");

  cov_block_read: cover property (r_reg.st == CKO_TX && r_reg.blk && r_reg.cnt_sent);
  cov_byte_write: cover property (r_reg.st == CKO_RACK && r_reg.ph == CKO_PH_DATA && !r_reg.rd);
  cov_strap_latch: cover property (pgood && !r_reg.strap_done);
  cov_panel_stop: cover property (r_reg.regs[6][`CKO_B_PANEL_STP] && !pstop_n);
  cov_gfx_low: cover property (r_reg.strap_done && !r_reg.gfx);
endmodule

//--- src/cko_out_gate.sv
// cko_out_gate.sv: per-output enables from fields, requests and stop
`timescale 1ns/1ps
`include "cko_cfg.svh"
module cko_out_gate
  import cko_pkg::*;
(
  cko_field_if.gate fld,
  input wire logic [7:0] clkreq_n_in,
  input wire logic pci_stop_n_in
);
  logic [7:0] b2, b3, b4, b5, b6;
  logic [11:0] hold, src;
  logic pstop;
  always_comb begin
    b2 = fld.regs[`CKO_OFF_SE_EN];
    b3 = fld.regs[`CKO_OFF_UPPER_EN];
    b4 = fld.regs[`CKO_OFF_LOWER_EN];
    b5 = fld.regs[`CKO_OFF_CREQ_AD];
    b6 = fld.regs[`CKO_OFF_CREQ_EH];
    pstop = !pci_stop_n_in;
    hold = 12'h000;
    // an enabled request that is released stops its mapped output
    if (b5[7] && clkreq_n_in[0]) hold[b5[6] ? 2 : 0] = 1'b1;
    if (b5[5] && clkreq_n_in[1]) hold[b5[4] ? 4 : 1] = 1'b1;
    if (b5[3] && clkreq_n_in[2]) hold[b5[2] ? 2 : 0] = 1'b1;
    if (b5[1] && clkreq_n_in[3]) hold[b5[0] ? 4 : 1] = 1'b1;
    if (b6[7] && clkreq_n_in[4]) hold[6] = 1'b1;
    if (b6[6] && clkreq_n_in[5]) hold[8] = 1'b1;
    if (b6[5] && clkreq_n_in[6]) hold[9] = 1'b1;
    if (b6[4] && clkreq_n_in[7]) hold[10] = 1'b1;
    src = {b3[7:2], 1'b0, b3[0], b4[7:6], b4[5] & fld.gfx_strap, b4[4] & fld.gfx_strap};
    src = src & ~hold;
    if (b6[`CKO_B_PCIE_STP] && pstop) src = 12'h000;
    fld.en.src_en = src;
    fld.en.ref_en = b2[7];
    fld.en.usb_en = b2[6];
    fld.en.free_pci_out0_en = b2[5];
    fld.en.pci_en = b2[4:0];
    fld.en.cpu_en = b4[3:2];
    fld.en.dot_clock_96_en = b4[4] & !fld.gfx_strap;
    fld.en.panel_clock_100_en = b4[5] & !fld.gfx_strap & !(b6[`CKO_B_PANEL_STP] && pstop);
  end
endmodule

//--- src/cko_sync.sv
// cko_sync.sv: three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module cko_sync
  import cko_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } cko_sync_st_t;
  cko_sync_st_t r_reg, r_next;
  always_comb begin
    r_next = r_reg;
    r_next.s1 = d_in;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    // take a new level only once stages two and three agree
    r_next.q = (r_reg.s2 & r_reg.s3) | (r_reg.q & (r_reg.s2 ^ r_reg.s3));
  end
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      r_reg <= {RST, RST, RST, RST};
    end else begin
      r_reg <= r_next;
    end
  end
  assign q_out = r_reg.q;
endmodule

//--- verif/cko_smb_host.sv
// cko_smb_host.sv: two-wire bus host model for the control register bank
`timescale 1ns/1ps
module cko_smb_host (
  input wire logic mclk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  // third of a bit; low phase stays well above the slave's sync delay
  task automatic q();
    repeat (10) @(posedge mclk_in);
    #1;
  endtask
  // start or repeated start: data falls while clock high
  task automatic start();
    sda_out = 1'b1;
    q();
    scl_out = 1'b1;
    q();
    sda_out = 1'b0;
    q();
    scl_out = 1'b0;
  endtask
  task automatic stop();
    q();
    sda_out = 1'b0;
    q();
    scl_out = 1'b1;
    q();
    sda_out = 1'b1;
    q();
  endtask
  // 1 releases the pulled-up line; sampled while clock high
  task automatic bit_x(input logic b, output logic s);
    q();
    sda_out = b;
    q();
    scl_out = 1'b1;
    q();
    s = sda_in;
    scl_out = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic a_in, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r[i]);
    end
    bit_x(a_in, ack);
  endtask
endmodule

//--- verif/tb_clock_output_control_regs.sv
// tb_clock_output_control_regs.sv: self-checking bench of the control register bank
`timescale 1ns/1ps
module tb_clock_output_control_regs import cko_pkg::*;;
  logic mclk_in, srst_in, scl, hsda, sda, pg, pd, cs, pci_stop_n, g, dout, doe;
  logic mgmt, main, stor, route, am, cm, ao, co, apply, a;
  logic [3:0] cfg;
  logic [2:0] fs;
  logic [7:0] clkreq_n, d;
  cko_en_t en;
  logic [7:0] bank [7];
  logic [31:0] seed;
  int n_errors, n_compared, cyc;
  localparam logic [7:0] WM [7] = '{8'h17, 8'h7e, 8'hff, 8'hfd, 8'hff, 8'hff, 8'hf3};
  localparam logic [7:0] RV [12] = '{8'h80, 8'hc0, 8'h20, 8'h30, 8'h08, 8'h0c, 8'h02, 8'h03,
    8'h80, 8'h40, 8'h20, 8'h10};
  localparam int RS [12] = '{0, 2, 1, 4, 0, 2, 1, 4, 6, 8, 9, 10};
  // open-drain data line with pull-up
  assign sda = hsda & ~(doe & ~dout);
  cko_smb_host host (.mclk_in(mclk_in), .sda_in(sda), .scl_out(scl), .sda_out(hsda));
  cko_ctrl_top dut (.mclk_in(mclk_in), .srst_in(srst_in), .smb_clk_in(scl), .smb_data_in(sda),
    .smb_data_out(dout), .smb_data_oe_out(doe), .cpu_freq_strap_in(fs), .graphics_clock_strap_in(g),
    .power_good_in(pg), .power_down_in(pd), .cpu_stop_in(cs), .pci_stop_n_in(pci_stop_n),
    .clkreq_n_in(clkreq_n), .clk_en_out(en), .mgmt_engine_mode_out(mgmt), .pcie_main_source_sel_out(main),
    .storage_clock_source_sel_out(stor), .shared_out0_route_out(route), .pll_a_spread_mode_out(am),
    .pll_c_spread_mode_out(cm), .pll_a_spread_on_out(ao), .pll_c_spread_on_out(co), .pll_c_cfg_out(cfg),
    .pll_c_cfg_apply_out(apply));
  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] rbk(input logic [6:0] i);
    return (i < 7) ? bank[i[2:0]] : 8'h00;
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic wt(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic upd(input logic [2:0] i, input logic [7:0] v);
    bank[i] = (bank[i] & ~WM[i]) | (v & WM[i]);
  endtask
  task automatic ld_def();
    bank = '{8'h01, 8'h03, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00};
    bank[0][7:5] = fs;
    bank[1][7] = ~g;
  endtask
  task automatic send(input logic [7:0] b);
    logic [7:0] r;
    logic ak;
    host.xfer(b, 1'b1, r, ak);
    check("ack", ak, 1'b0);
  endtask
  task automatic wr(input logic [6:0] idx, input logic [7:0] v);
    host.start();
    send(8'hd2);
    send({1'b1, idx});
    send(v);
    host.stop();
    if (idx < 7) upd(idx[2:0], v);
  endtask
  task automatic rdc(input logic [6:0] idx);
    logic [7:0] v;
    logic ak;
    host.start();
    send(8'hd2);
    send({1'b1, idx});
    host.start();
    send(8'hd3);
    host.xfer(8'hff, 1'b1, v, ak);
    host.stop();
    check("read", v, rbk(idx));
  endtask
  task automatic chk_outs();
    check("ctl", {mgmt, main, stor, route, am, cm, ao, co, cfg, apply}, {bank[0][4], bank[0][2], bank[0][1],
      ~g, bank[1][6], bank[1][5], bank[4][1], bank[4][0], bank[1][4:1], ~bank[0][2]});
    check("en", {en.ref_en, en.usb_en, en.free_pci_out0_en, en.pci_en, en.cpu_en, en.src_en, en.dot_clock_96_en,
      en.panel_clock_100_en}, {bank[2], bank[4][3:2], bank[3][7:2], 1'b0, bank[3][0], bank[4][7:6],
      bank[4][5:4] & {2{g}}, bank[4][4] & ~g, bank[4][5] & ~g});
  endtask
  initial begin
    seed = 32'he162c475;
    srst_in = 1'b1;
    pg = 1'b0;
    pd = 1'b0;
    cs = 1'b0;
    pci_stop_n = 1'b1;
    clkreq_n = 8'h00;
    fs = seed[2:0];
    g = 1'b1;
    wt(2);
    srst_in = 1'b0;
    pg = 1'b1;
    wt(20);
    ld_def();
    for (int i = 0; i < 7; i++) rdc(7'(i));
    chk_outs();
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      wr(i < 8 ? 7'h05 : 7'h06, RV[i]);
      clkreq_n = 8'hff;
      wt(10);
      check("req off", en.src_en[RS[i]], 1'b0);
      clkreq_n[i < 8 ? i / 2 : i - 4] = 1'b0;
      wt(10);
      check("req on", en.src_en[RS[i]], 1'b1);
      wr(i < 8 ? 7'h05 : 7'h06, 8'h00);
    end
    clkreq_n = 8'h00;
    $display("test requests done");
    wr(7'h06, 8'h01);
    pci_stop_n = 1'b0;
    wt(10);
    check("stopped", {en.src_en[4], en.ref_en}, 2'b01);
    pci_stop_n = 1'b1;
    wt(10);
    check("running", en.src_en[4], 1'b1);
    wr(7'h06, 8'h00);
    $display("test stop done");
    host.start();
    send(8'hd2);
    send(8'h00);
    send(8'h07);
    for (int i = 0; i < 7; i++) begin
      seed = lfsr(seed);
      send(seed[7:0]);
      upd(3'(i), seed[7:0]);
    end
    host.stop();
    host.start();
    send(8'hd2);
    send(8'h00);
    host.start();
    send(8'hd3);
    host.xfer(8'hff, 1'b0, d, a);
    check("count", d, 8'h07);
    for (int i = 0; i < 7; i++) begin
      host.xfer(8'hff, i == 6, d, a);
      check("block", d, rbk(7'(i)));
    end
    host.stop();
    $display("test block done");
    for (int n = 0; n < 8; n++) begin
      seed = lfsr(seed);
      wr({4'h0, seed[10:8]}, seed[7:0]);
      rdc({4'h0, seed[10:8]});
    end
    wr(7'h7f, 8'h5a);
    rdc(7'h7f);
    chk_outs();
    host.start();
    host.xfer(8'ha0, 1'b1, d, a);
    check("foreign addr", a, 1'b1);
    host.stop();
    $display("test random done");
    wr(7'h05, 8'h3c);
    wr(7'h00, 8'h00);
    pd = 1'b1;
    wt(12);
    pd = 1'b0;
    wt(4);
    ld_def();
    for (int i = 0; i < 7; i++) rdc(7'(i));
    pd = 1'b1;
    cs = 1'b1;
    pci_stop_n = 1'b0;
    wt(12);
    check("mode", mgmt, 1'b1);
    bank[0][4] = 1'b1;
    pd = 1'b0;
    cs = 1'b0;
    pci_stop_n = 1'b1;
    wt(12);
    rdc(7'h00);
    chk_outs();
    $display("test power pins done");
    // second reset with the graphics strap low: straps are latched again
    seed = lfsr(seed);
    fs = seed[2:0];
    g = 1'b0;
    srst_in = 1'b1;
    wt(2);
    srst_in = 1'b0;
    wt(20);
    ld_def();
    for (int i = 0; i < 7; i++) rdc(7'(i));
    chk_outs();
    wr(7'h06, 8'h02);
    pci_stop_n = 1'b0;
    wt(10);
    check("panel stop", {en.panel_clock_100_en, en.dot_clock_96_en, en.src_en[4]}, 3'b011);
    pci_stop_n = 1'b1;
    wt(10);
    check("panel run", en.panel_clock_100_en, 1'b1);
    $display("test strap low done");
    end_sim();
  end
endmodule
